// ---- src/adc_regs_pkg.sv ----
/*
 * Constants, types and register map for the converter result,
 * repeat and filter register group.
 * Assumes a byte-wide register port with a 12-bit address.
 */
package adc_regs_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CLK_DIV = 12'hF52;
    localparam logic [11:0] ADDR_ACQ = 12'hF57;
    localparam logic [11:0] ADDR_CAP = 12'hF58;
    localparam logic [11:0] ADDR_PRE = 12'hF59;
    localparam logic [11:0] ADDR_PRIOR = 12'hF5C;
    localparam logic [11:0] ADDR_RESULT = 12'hF5E;
    localparam logic [11:0] ADDR_STATUS = 12'hF60;
    localparam logic [11:0] ADDR_RPT_TGT = 12'hF61;
    localparam logic [11:0] ADDR_RPT_CNT = 12'hF62;
    localparam logic [11:0] ADDR_FILTER = 12'hF6D;
    localparam logic [11:0] ADDR_CTRL = 12'hF70;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'hF71;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'hF72;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int CTRL_JUSTIFY_BIT = 0;
    localparam int CTRL_PRIOR_SRC_BIT = 1;
    localparam int STAT_OVF_BIT = 7;
    localparam int STAT_UPD_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_CHECK_BIT = 1;
    localparam int IRQ_UPD_BIT = 2;
    localparam int CAP_WIDTH = 5;
    localparam int DIV_WIDTH = 6;
    localparam int RES_BITS = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [2:0] {
        STG_IDLE = 3'b000,
        STG_PRECHARGE = 3'b001,
        STG_ACQUIRE = 3'b010,
        STG_CONVERT = 3'b011
    } stage_t;

    typedef enum logic [2:0] {
        MODE_BASIC = 3'b000,
        MODE_ACCUM = 3'b001,
        MODE_AVERAGE = 3'b010,
        MODE_BURST = 3'b011,
        MODE_LPF = 3'b100
    } compute_mode_t;

    typedef struct packed {
        logic done;
        logic [RES_BITS-1:0] value;
    } analog_result_t;

    typedef struct packed {
        logic update;
        logic overflow;
        compute_mode_t mode;
        logic [2:0] accumulator_shift;
        logic [15:0] accumulator_value;
        logic [15:0] lpf_value;
    } compute_in_t;

endpackage

// ---- src/adc_result_regs.sv ----
/*
 * Result, repeat and filter register group of the converter,
 * with its conversion stage sequencer and clock divider.
 * Assumes the analog core reports one done pulse per convert
 * request, and the compute unit pulses update with its values.
 */
`timescale 1ns/1ns
module adc_result_regs (
    input wire logic sys_clk, // 250 MHz clock
    input wire logic arst_n, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic [11:0] reg_addr, // Register byte address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic conv_start, // Conversion trigger pulse
    input adc_regs_pkg::analog_result_t analog_in, // From core
    input adc_regs_pkg::compute_in_t compute_in, // From compute
    output adc_regs_pkg::stage_t stage, // Current stage
    output logic convert_req, // Pulse: start conversion
    output logic [4:0] extra_cap, // Extra sample capacitance, pF
    output logic threshold_check, // Pulse: check threshold now
    output logic irq // Level interrupt
);
    import adc_regs_pkg::*;

    logic [7:0] acq_q;
    logic [7:0] pre_q;
    logic [7:0] cap_q;
    logic [DIV_WIDTH-1:0] div_sel_q;
    logic [7:0] rpt_tgt_q;
    logic [7:0] rpt_cnt_q;
    logic [15:0] result_q;
    logic [15:0] prior_q;
    logic [15:0] filter_q;
    logic justify_q;
    logic prior_src_q;
    logic upd_flag_q;
    logic ovf_flag_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic irq_q;
    stage_t stage_q;
    logic [7:0] stage_cnt_q;
    logic convert_req_q;
    logic check_q;
    logic [DIV_WIDTH:0] div_cnt_q;
    logic tick_q;

    logic [15:0] result_fmt;
    logic [15:0] filter_d;
    logic repeat_mode;
    logic [7:0] rpt_next;
    logic check_hit;
    logic done_ev;
    logic [DIV_WIDTH:0] div_last;
    logic wr_stat;
    logic rd_irq;

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    always_comb begin
        if (justify_q) begin
            result_fmt = {6'h00, analog_in.value};
        end else begin
            result_fmt = {analog_in.value, 6'h00};
        end
    end

    always_comb begin
        unique case (compute_in.mode)
            MODE_LPF: filter_d = compute_in.lpf_value;
            default: filter_d = compute_in.accumulator_value
                >> compute_in.accumulator_shift;
        endcase
    end

    always_comb begin
        unique case (compute_in.mode)
            MODE_LPF, MODE_BURST, MODE_AVERAGE: repeat_mode = 1'b1;
            default: repeat_mode = 1'b0;
        endcase
    end

    assign done_ev = analog_in.done && stage_q == STG_CONVERT;
    assign rpt_next = rpt_cnt_q + 8'h01;
    assign check_hit = done_ev && repeat_mode
        && rpt_next == rpt_tgt_q;
    assign div_last = {div_sel_q, 1'b1};
    assign wr_stat = reg_wr && reg_addr == ADDR_STATUS;
    assign rd_irq = reg_rd && reg_addr == ADDR_IRQ_STAT;

    // ------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            if (div_cnt_q >= div_last) begin
                div_cnt_q <= '0;
                tick_q <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h01;
                tick_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stage sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= STG_IDLE;
            stage_cnt_q <= RST_BYTE;
            convert_req_q <= 1'b0;
        end else if (clk_en) begin
            convert_req_q <= 1'b0;
            unique case (stage_q)
                STG_IDLE: begin
                    if (conv_start) begin
                        if (pre_q != 8'h00) begin
                            stage_q <= STG_PRECHARGE;
                            stage_cnt_q <= pre_q;
                        end else if (acq_q != 8'h00) begin
                            stage_q <= STG_ACQUIRE;
                            stage_cnt_q <= acq_q;
                        end else begin
                            stage_q <= STG_CONVERT;
                            convert_req_q <= 1'b1;
                        end
                    end
                end
                STG_PRECHARGE: begin
                    if (tick_q) begin
                        stage_cnt_q <= stage_cnt_q - 8'h01;
                        if (stage_cnt_q == 8'h01) begin
                            if (acq_q != 8'h00) begin
                                stage_q <= STG_ACQUIRE;
                                stage_cnt_q <= acq_q;
                            end else begin
                                stage_q <= STG_CONVERT;
                                convert_req_q <= 1'b1;
                            end
                        end
                    end
                end
                STG_ACQUIRE: begin
                    if (tick_q) begin
                        stage_cnt_q <= stage_cnt_q - 8'h01;
                        if (stage_cnt_q == 8'h01) begin
                            stage_q <= STG_CONVERT;
                            convert_req_q <= 1'b1;
                        end
                    end
                end
                STG_CONVERT: begin
                    if (analog_in.done) begin
                        stage_q <= STG_IDLE;
                    end
                end
                default: stage_q <= STG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Plain control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acq_q <= RST_BYTE;
            pre_q <= RST_BYTE;
            cap_q <= RST_BYTE;
            div_sel_q <= '0;
            rpt_tgt_q <= RST_BYTE;
            justify_q <= 1'b0;
            prior_src_q <= 1'b0;
            irq_mask_q <= '0;
        end else if (clk_en && reg_wr) begin
            unique case (reg_addr)
                ADDR_ACQ: acq_q <= reg_wdata;
                ADDR_PRE: pre_q <= reg_wdata;
                ADDR_CAP: cap_q <= {3'h0,
                    reg_wdata[CAP_WIDTH-1:0]};
                ADDR_CLK_DIV: div_sel_q <= reg_wdata[DIV_WIDTH-1:0];
                ADDR_RPT_TGT: rpt_tgt_q <= reg_wdata;
                ADDR_CTRL: begin
                    justify_q <= reg_wdata[CTRL_JUSTIFY_BIT];
                    prior_src_q <= reg_wdata[CTRL_PRIOR_SRC_BIT];
                end
                ADDR_IRQ_MASK: irq_mask_q <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Repeat counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rpt_cnt_q <= RST_BYTE;
            check_q <= 1'b0;
        end else if (clk_en) begin
            check_q <= check_hit;
            if (check_hit) begin
                rpt_cnt_q <= RST_BYTE;
            end else if (done_ev && repeat_mode) begin
                rpt_cnt_q <= rpt_next;
            end else if (reg_wr && reg_addr == ADDR_RPT_CNT) begin
                rpt_cnt_q <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion result
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= RST_WORD;
        end else if (clk_en) begin
            if (done_ev) begin
                result_q <= result_fmt;
            end else if (reg_wr && reg_addr == ADDR_RESULT) begin
                result_q[7:0] <= reg_wdata;
            end else if (reg_wr && reg_addr == ADDR_RESULT + 12'h001) begin
                result_q[15:8] <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Prior result capture at conversion start
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prior_q <= RST_WORD;
        end else if (clk_en && conv_start && stage_q == STG_IDLE) begin
            if (prior_src_q) begin
                prior_q <= filter_q;
            end else begin
                prior_q <= result_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Filter output and compute flags
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            filter_q <= RST_WORD;
        end else if (clk_en && compute_in.update) begin
            filter_q <= filter_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            upd_flag_q <= 1'b0;
            ovf_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (compute_in.update || compute_in.overflow) begin
                upd_flag_q <= 1'b1;
            end else if (wr_stat && !reg_wdata[STAT_UPD_BIT]) begin
                upd_flag_q <= 1'b0;
            end
            if (compute_in.overflow) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_stat && !reg_wdata[STAT_OVF_BIT]) begin
                ovf_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, cleared by read, set wins
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_stat_q[IRQ_DONE_BIT] <= done_ev
                || (irq_stat_q[IRQ_DONE_BIT] && !rd_irq);
            irq_stat_q[IRQ_CHECK_BIT] <= check_hit
                || (irq_stat_q[IRQ_CHECK_BIT] && !rd_irq);
            irq_stat_q[IRQ_UPD_BIT] <= compute_in.update
                || (irq_stat_q[IRQ_UPD_BIT] && !rd_irq);
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= RST_BYTE;
        end else if (clk_en) begin
            rdata_q <= RST_BYTE;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_ACQ: rdata_q <= acq_q;
                    ADDR_PRE: rdata_q <= pre_q;
                    ADDR_CAP: rdata_q <= cap_q;
                    ADDR_CLK_DIV: rdata_q <= {2'h0, div_sel_q};
                    ADDR_RPT_TGT: rdata_q <= rpt_tgt_q;
                    ADDR_RPT_CNT: rdata_q <= rpt_cnt_q;
                    ADDR_PRIOR: rdata_q <= prior_q[7:0];
                    ADDR_PRIOR + 12'h001: rdata_q <= prior_q[15:8];
                    ADDR_RESULT: rdata_q <= result_q[7:0];
                    ADDR_RESULT + 12'h001: rdata_q <= result_q[15:8];
                    ADDR_FILTER: rdata_q <= filter_q[7:0];
                    ADDR_FILTER + 12'h001: rdata_q <= filter_q[15:8];
                    ADDR_STATUS: rdata_q <= {ovf_flag_q, 2'h0,
                        upd_flag_q, 1'b0, stage_q};
                    ADDR_CTRL: rdata_q <= {6'h00, prior_src_q,
                        justify_q};
                    ADDR_IRQ_STAT: rdata_q <= {5'h00, irq_stat_q};
                    ADDR_IRQ_MASK: rdata_q <= {5'h00, irq_mask_q};
                    default: rdata_q <= RST_BYTE;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign stage = stage_q;
    assign convert_req = convert_req_q;
    assign extra_cap = cap_q[CAP_WIDTH-1:0];
    assign threshold_check = check_q;
    assign irq = irq_q;

endmodule // adc_result_regs

// ---- tb/adc_core_model.sv ----
/*
 * Far-side model: analog core answering convert requests.
 * Assumes the bench sets the reported sample and the delay.
 */
`timescale 1ns/1ns
module adc_core_model (
    input wire logic sys_clk, // Clock
    input wire logic arst_n, // Async reset, active low
    input wire logic convert_req, // Start of a conversion
    input wire logic [3:0] dly, // Cycles until done
    input wire logic [9:0] sample, // Value to report
    output adc_regs_pkg::analog_result_t analog_in // Done and value
);
    import adc_regs_pkg::*;
    // --------------------------------------------
    // Delayed done pulse, value scrambled otherwise
    // --------------------------------------------
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
            analog_in <= '0;
        end else begin
            analog_in.done <= (cnt_q == 4'h1);
            analog_in.value <= (cnt_q == 4'h1) ? sample : ~analog_in.value;
            if (convert_req)
                cnt_q <= dly;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule // adc_core_model

// ---- tb/adc_result_regs_asserts.sv ----
/*
 * Port checker for the result register group.
 * Assumes it is bound to adc_result_regs.
 */
`timescale 1ns/1ns
module adc_result_regs_asserts (
    input wire logic sys_clk, // Clock
    input wire logic arst_n, // Async reset
    input wire logic clk_en, // Run enable
    input wire logic [11:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic conv_start, // Trigger
    input adc_regs_pkg::analog_result_t analog_in, // Core
    input adc_regs_pkg::compute_in_t compute_in, // Compute
    input adc_regs_pkg::stage_t stage, // Stage
    input wire logic convert_req, // Convert pulse
    input wire logic [4:0] extra_cap, // Capacitance
    input wire logic threshold_check, // Check pulse
    input wire logic irq // Interrupt
);
    import adc_regs_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // --------------------------------------------
    // Properties
    // --------------------------------------------
    chk_cap_write: assert property (
        reg_wr && clk_en && reg_addr == ADDR_CAP
        |=> extra_cap == $past(reg_wdata[4:0])) else $error("cap wrong");
    chk_start_leaves_idle: assert property (
        clk_en && conv_start && stage == STG_IDLE
        |=> stage != STG_IDLE) else $error("no start");
    chk_req_on_entry: assert property (
        convert_req && $past(clk_en)
        |-> stage == STG_CONVERT && $past(stage) != STG_CONVERT)
        else $error("convert pulse off entry");
    chk_req_single: assert property (
        convert_req && clk_en
        |=> !convert_req) else $error("convert pulse long");
    chk_done_ends: assert property (
        clk_en && analog_in.done && stage == STG_CONVERT
        |=> stage == STG_IDLE) else $error("done ignored");
    chk_check_cause: assert property (
        threshold_check && $past(clk_en)
        |-> $past(analog_in.done) && $past(stage) == STG_CONVERT)
        else $error("check without done");
    chk_check_mode: assert property (
        threshold_check && $past(clk_en)
        |-> $past(compute_in.mode) inside {MODE_AVERAGE, MODE_BURST,
        MODE_LPF}) else $error("check in wrong mode");
    chk_rdata_idle: assert property (
        clk_en && !reg_rd
        |=> reg_rdata == 8'h00) else $error("read data not idle");
    cover property (threshold_check);
    cover property (convert_req);
    cover property (irq);
endmodule // adc_result_regs_asserts

bind adc_result_regs adc_result_regs_asserts adc_result_regs_asserts_i (
    .sys_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_start, .analog_in, .compute_in, .stage,
    .convert_req, .extra_cap, .threshold_check, .irq);

// ---- tb/adc_result_regs_tb_top.sv ----
/*
 * Self-checking bench for the result register group.
 * Assumes the core model answers each convert request.
 */
`timescale 1ns/1ns
module adc_result_regs_tb_top;
    import adc_regs_pkg::*;
    logic sys_clk = 0, arst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic conv_start = 0, convert_req, threshold_check, irq;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d8;
    logic [9:0] sample = 10'h000;
    logic [3:0] dly = 4'h1;
    logic [4:0] extra_cap;
    analog_result_t analog_in;
    compute_in_t compute_in = '0;
    stage_t stage;
    int miscompares = 0, compares = 0, pre_cyc, acq_cyc, chk_cnt;
    logic [11:0] ra [12] = '{12'hF57, 12'hF58, 12'hF5C, 12'hF5D, 12'hF5E,
        12'hF5F, 12'hF60, 12'hF61, 12'hF62, 12'hF70, 12'hF71, 12'hF72};
    logic [11:0] wa [6] = '{12'hF57, 12'hF58, 12'hF61, 12'hF62, 12'hF5E,
        12'hF5F};
    logic [7:0] wv [6] = '{8'hA5, 8'h15, 8'h3C, 8'h5A, 8'hC3, 8'h81};
    logic [11:0] ro [3] = '{12'hF5C, 12'hF6D, 12'hF55};
    compute_mode_t md [5] = '{MODE_BASIC, MODE_ACCUM, MODE_AVERAGE,
        MODE_BURST, MODE_LPF};
    always #2 sys_clk = ~sys_clk;
    adc_result_regs adc_result_regs_i (.sys_clk, .arst_n, .clk_en,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_start,
        .analog_in, .compute_in, .stage, .convert_req, .extra_cap,
        .threshold_check, .irq);
    adc_core_model adc_core_model_i (.sys_clk, .arst_n, .convert_req,
        .dly, .sample, .analog_in);
    always @(posedge sys_clk) begin
        pre_cyc += (stage == STG_PRECHARGE);
        acq_cyc += (stage == STG_ACQUIRE);
        chk_cnt += (threshold_check === 1'b1);
    end
    // --------------------------------------------
    // Access tasks
    // --------------------------------------------
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    task automatic rchk(logic [11:0] a, logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 d8 = reg_rdata;
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d8});
    endtask
    task automatic conv(logic [9:0] v);
        int i;
        sample <= v;
        pre_cyc = 0;
        acq_cyc = 0;
        i = 0;
        @(posedge sys_clk);
        conv_start <= 1;
        @(posedge sys_clk);
        conv_start <= 0;
        #1;
        while (stage !== STG_IDLE && i < 300) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i >= 300)
            chk("conversion end", 16'h0001, 16'h0000);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic upd(compute_mode_t m, logic [15:0] acc, logic [15:0] lp,
            logic ov);
        @(posedge sys_clk);
        compute_in <= '{!ov, ov, m, 3'h2, acc, lp};
        @(posedge sys_clk);
        compute_in.update <= 0;
        compute_in.overflow <= 0;
    endtask
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        print_verdict;
    end
    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1;
        foreach (ra[i]) rchk(ra[i], 8'h00);
        foreach (wa[i]) wr(wa[i], wv[i]);
        foreach (wa[i]) rchk(wa[i], wv[i]);
        chk("extra_cap", 16'h0015, {11'h000, extra_cap});
        // Write while frozen is lost
        @(posedge sys_clk);
        clk_en <= 0;
        wr(12'hF57, 8'h77);
        clk_en <= 1;
        rchk(12'hF57, 8'hA5);
        foreach (ro[i]) begin
            wr(ro[i], 8'hFF);
            rchk(ro[i], 8'h00);
        end
        foreach (wa[i]) wr(wa[i], 8'h00);
        wr(12'hF70, 8'h01);
        wr(12'hF72, 8'h01);
        conv(10'h2B7);
        chk("stage cycles", 16'h0000,
            16'(pre_cyc + acq_cyc));
        rchk(12'hF5E, 8'hB7);
        rchk(12'hF5F, 8'h02);
        chk("irq", 16'h0001, {15'h0000, irq});
        rchk(12'hF71, 8'h01);
        // Interrupt line follows the cleared status one cycle late
        @(posedge sys_clk);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        wr(12'hF70, 8'h00);
        conv(10'h2B7);
        rchk(12'hF5E, 8'hC0);
        rchk(12'hF5F, 8'hAD);
        rchk(12'hF5C, 8'hB7);
        rchk(12'hF5D, 8'h02);
        wr(12'hF52, 8'h01);
        wr(12'hF59, 8'h02);
        wr(12'hF57, 8'h03);
        dly <= 4'h9;
        conv(10'h155);
        chk("pre len", 16'h0001,
            16'(pre_cyc >= 5 && pre_cyc <= 8));
        chk("acq len", 16'h0001,
            16'(acq_cyc >= 9 && acq_cyc <= 12));
        dly <= 4'h1;
        wr(12'hF59, 8'h00);
        wr(12'hF57, 8'h00);
        upd(MODE_ACCUM, 16'h1234, 16'h0000, 0);
        rchk(12'hF6D, 8'h8D);
        rchk(12'hF6E, 8'h04);
        rchk(12'hF60, 8'h10);
        upd(MODE_LPF, 16'h1234, 16'hBEEF, 0);
        rchk(12'hF6D, 8'hEF);
        rchk(12'hF6E, 8'hBE);
        wr(12'hF70, 8'h02);
        conv(10'h000);
        rchk(12'hF5C, 8'hEF);
        rchk(12'hF5D, 8'hBE);
        wr(12'hF61, 8'h02);
        foreach (md[i]) begin
            upd(md[i], 16'h0000, 16'h0000, 0);
            wr(12'hF62, 8'h00);
            chk_cnt = 0;
            conv(10'h001);
            rchk(12'hF62, {7'h00, md[i] >= MODE_AVERAGE});
            conv(10'h001);
            chk("checks", {15'h0000, md[i] >= MODE_AVERAGE},
                16'(chk_cnt));
            rchk(12'hF62, 8'h00);
        end
        upd(MODE_BASIC, 16'h0000, 16'h0000, 1);
        rchk(12'hF60, 8'h90);
        wr(12'hF60, 8'h00);
        rchk(12'hF60, 8'h00);
        wr(12'hF72, 8'h00);
        rchk(12'hF71, 8'h07);
        conv(10'h005);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        print_verdict;
    end
endmodule // adc_result_regs_tb_top
